/* inc/hpif_pkg.sv */
// constants, types and request carrier for the host port block
package hpif_pkg;

	// ==========================================================
	// access-select codes
	localparam logic [1:0] SEL_CONTROL   = 2'h0;
	localparam logic [1:0] SEL_POINTER   = 2'h1;
	localparam logic [1:0] SEL_DATA_AUTO = 2'h2;
	localparam logic [1:0] SEL_DATA_FIX  = 2'h3;

	// ==========================================================
	// addressing
	localparam int          ADDR_W      = 32;
	localparam int          DATA_W      = 32;
	localparam int          HALF_W      = 16;
	localparam logic [31:0] ADDR_STEP   = 32'h0000_0004;
	localparam logic [31:0] PTR_RESET   = 32'h0000_0000;
	localparam logic [1:0]  LSB_WORD    = 2'h0;
	localparam logic [1:0]  LSB_HALF_HI = 2'h2;
	localparam logic [1:0]  LSB_HALF_LO = 2'h0;

	// ==========================================================
	// control register bit positions
	localparam int BIT_ORDER    = 0;
	localparam int BIT_DSP_IRQ  = 1;
	localparam int BIT_HOST_IRQ = 2;
	localparam int BIT_BUSY     = 3;
	localparam int BIT_WIDE     = 4;

	// ==========================================================
	// buffering
	localparam int FIFO_DEPTH = 4;

	// ==========================================================
	// read state
	typedef enum logic [1:0]
	{
		RD_IDLE  = 2'b00,
		RD_WAIT  = 2'b01,
		RD_READY = 2'b10
	} hpif_rd_e;

	// internal memory request
	typedef struct packed
	{
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              write;
		logic [1:0]        lsb;
	} hpif_req_s;

	localparam int REQ_W = $bits(hpif_req_s);

endpackage : hpif_pkg

/* core/hpif_port.sv */
// host port block: pin side, pointers, halfword merging and request FIFO
// ==========================================================
`timescale 1ns/1ps

// ==========================================================
// request FIFO
module hpif_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             srst,
	// fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0]    wrPtr_r;
	logic [PW-1:0]    rdPtr_r;
	logic [CW-1:0]    count_r;
	logic             push;
	logic             pop;

	assign push    = inValid && inReady;
	assign pop     = outValid && outReady;
	assign inReady = (count_r != FULL);
	assign outValid = (count_r != '0);
	assign outData = store[rdPtr_r];

	always_ff @(posedge mclk)
	begin
		if (push)
			store[wrPtr_r] <= inData;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end
		else
		begin
			if (push)
				wrPtr_r <= (wrPtr_r == LAST) ? '0 : wrPtr_r + 1'b1;
			if (pop)
				rdPtr_r <= (rdPtr_r == LAST) ? '0 : rdPtr_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end

endmodule : hpif_fifo

// ==========================================================
// top
module hpif_port
	import hpif_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              srst,
	// configuration straps
	input  wire logic              widePortStrap,
	input  wire logic              littleEndianStrap,
	// host pins
	input  wire logic [DATA_W-1:0] hostDataIn,
	output logic      [DATA_W-1:0] hostDataOut,
	output logic                   hostDataOeLow,
	output logic                   hostDataOeHigh,
	input  wire logic [1:0]        accessSelect,
	input  wire logic              halfwordIdent,
	input  wire logic              readNotWrite,
	input  wire logic              portSelectN,
	input  wire logic              dataStrobeAN,
	input  wire logic              dataStrobeBN,
	input  wire logic              addrStrobeN,
	output logic                   portNotReady,
	output logic                   hostIrqN,
	// internal memory side
	output logic                   memReqValid,
	input  wire logic              memReqReady,
	output hpif_req_s              memReq,
	input  wire logic              memRdValid,
	input  wire logic [DATA_W-1:0] memRdData,
	// DSP CPU side
	input  wire logic              cpuPtrWrEn,
	input  wire logic              cpuPtrSelRead,
	input  wire logic [ADDR_W-1:0] cpuPtrData,
	input  wire logic              cpuHostIrqSet,
	output logic      [ADDR_W-1:0] writeAddressPointer,
	output logic      [ADDR_W-1:0] readAddressPointer,
	output logic                   halfwordOrder,
	output logic                   widePortMode,
	output logic                   dspIrq
);
	function automatic logic [DATA_W-1:0] joinHalves(
		input logic [HALF_W-1:0] first,
		input logic [HALF_W-1:0] second,
		input logic              order
	);
		// order 0: first is most significant
		return order ? {second, first} : {first, second};
	endfunction : joinHalves

	function automatic logic [HALF_W-1:0] pickHalf(
		input logic [DATA_W-1:0] word,
		input logic              second,
		input logic              order
	);
		return (second ^ order) ? word[HALF_W-1:0] : word[DATA_W-1:HALF_W];
	endfunction : pickHalf

	// ==========================================================
	// strobe synchronisers
	logic csS1_r, csS2_r, dsaS1_r, dsaS2_r, dsbS1_r, dsbS2_r, asS1_r, asS2_r;
	logic strobeLast_r;
	logic asLast_r;
	logic strobeNow;
	logic strobeFall;
	logic strobeRise;
	logic asFall;
	logic rawStrobe;

	always_ff @(posedge mclk)
	begin
		csS1_r  <= portSelectN;
		csS2_r  <= csS1_r;
		dsaS1_r <= dataStrobeAN;
		dsaS2_r <= dsaS1_r;
		dsbS1_r <= dataStrobeBN;
		dsbS2_r <= dsbS1_r;
		asS1_r  <= addrStrobeN;
		asS2_r  <= asS1_r;
	end

	assign strobeNow = !csS2_r && (dsaS2_r ^ dsbS2_r);
	assign rawStrobe = !portSelectN && (dataStrobeAN ^ dataStrobeBN);
	assign strobeFall = strobeNow && !strobeLast_r;
	assign strobeRise = !strobeNow && strobeLast_r;
	assign asFall = !asS2_r && asLast_r;

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			strobeLast_r <= 1'b0;
			asLast_r     <= 1'b1;
		end
		else
		begin
			strobeLast_r <= strobeNow;
			asLast_r     <= asS2_r;
		end
	end

	// ==========================================================
	// width strap and control latching
	logic       wide_r;
	logic       byAs_r;
	logic [1:0] selLat_r;
	logic       identLat_r;
	logic       rnwLat_r;
	logic [1:0] curSel;
	logic       curIdent;
	logic       curRnw;
	logic       curFirst;
	logic       curLast;

	always_ff @(posedge mclk)
	begin
		if (srst)
			wide_r <= widePortStrap;
	end

	// latch on address or strobe fall
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			byAs_r     <= 1'b0;
			selLat_r   <= SEL_CONTROL;
			identLat_r <= 1'b0;
			rnwLat_r   <= 1'b1;
		end
		else if (asFall)
		begin
			byAs_r     <= 1'b1;
			selLat_r   <= accessSelect;
			identLat_r <= halfwordIdent;
			rnwLat_r   <= readNotWrite;
		end
		else if (strobeFall && !byAs_r)
		begin
			selLat_r   <= accessSelect;
			identLat_r <= halfwordIdent;
			rnwLat_r   <= readNotWrite;
		end
		else if (strobeRise)
			byAs_r <= 1'b0;
	end

	assign curSel   = (byAs_r || !strobeFall) ? selLat_r : accessSelect;
	assign curIdent = (byAs_r || !strobeFall) ? identLat_r : halfwordIdent;
	assign curRnw   = (byAs_r || !strobeFall) ? rnwLat_r : readNotWrite;
	assign curFirst = wide_r || !curIdent;
	assign curLast  = wide_r || curIdent;

	// ==========================================================
	// write data capture and halfword merge
	logic [DATA_W-1:0] wrData_r;
	logic [HALF_W-1:0] firstHalf_r;
	logic [DATA_W-1:0] wrWord;
	logic              hostWrite;
	logic              dataSel;

	// raw pins sampled while strobe open, consumed at synchronised rise
	always_ff @(posedge mclk)
	begin
		if (rawStrobe)
			wrData_r <= hostDataIn;
	end

	assign hostWrite = strobeRise && !curRnw;
	assign dataSel   = curSel[1];

	always_ff @(posedge mclk)
	begin
		if (hostWrite && !wide_r && !curIdent)
			firstHalf_r <= wrData_r[HALF_W-1:0];
	end

	assign wrWord = wide_r ? wrData_r
		: joinHalves(firstHalf_r, wrData_r[HALF_W-1:0], halfwordOrder);

	// ==========================================================
	// request path
	hpif_req_s reqIn;
	logic      reqValid;
	logic      reqReady;
	logic      wrEnq;
	logic      rdEnq;
	hpif_rd_e  rdState_r;

	assign wrEnq = hostWrite && dataSel && curLast;
	assign rdEnq = strobeFall && curRnw && dataSel && curFirst;
	assign reqValid = wrEnq || rdEnq;

	always_comb
	begin
		reqIn.addr  = wrEnq ? writeAddressPointer : readAddressPointer;
		reqIn.wdata = wrWord;
		reqIn.write = wrEnq;
		reqIn.lsb   = LSB_WORD;
	end

	hpif_fifo #(
		.WIDTH (REQ_W),
		.DEPTH (DEPTH)
	) reqFifo (
		.mclk     (mclk),
		.srst     (srst),
		.inValid  (reqValid),
		.inReady  (reqReady),
		.inData   (reqIn),
		.outValid (memReqValid),
		.outReady (memReqReady),
		.outData  (memReq)
	);

	// ==========================================================
	// read word tracking
	logic [DATA_W-1:0] rdWord_r;
	logic [DATA_W-1:0] ctlWord;
	logic              busy;

	assign busy = (rdState_r == RD_WAIT) || !reqReady;

	always_comb
	begin
		ctlWord               = '0;
		ctlWord[BIT_ORDER]    = halfwordOrder;
		ctlWord[BIT_HOST_IRQ] = !hostIrqN;
		ctlWord[BIT_BUSY]     = busy;
		ctlWord[BIT_WIDE]     = wide_r;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			rdState_r <= RD_IDLE;
		else
		begin
			case (rdState_r)
				RD_IDLE, RD_READY:
				begin
					if (rdEnq && reqReady)
						rdState_r <= RD_WAIT;
				end
				RD_WAIT:
				begin
					if (memRdValid)
						rdState_r <= RD_READY;
				end
				default:
					rdState_r <= RD_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rdState_r == RD_WAIT && memRdValid)
			rdWord_r <= memRdData;
		else if (strobeFall && curRnw && !dataSel && curFirst)
			rdWord_r <= (curSel == SEL_CONTROL) ? ctlWord : readAddressPointer;
	end

	// ==========================================================
	// pointers
	logic [HALF_W-1:0] ptrFirst_r;
	logic [ADDR_W-1:0] ptrWord;

	always_ff @(posedge mclk)
	begin
		if (hostWrite && curSel == SEL_POINTER && !wide_r && !curIdent)
			ptrFirst_r <= wrData_r[HALF_W-1:0];
	end

	assign ptrWord = wide_r ? wrData_r
		: joinHalves(ptrFirst_r, wrData_r[HALF_W-1:0], halfwordOrder);

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			writeAddressPointer <= PTR_RESET;
			readAddressPointer  <= PTR_RESET;
		end
		else if (hostWrite && curSel == SEL_POINTER && curLast)
		begin
			writeAddressPointer <= ptrWord;
			readAddressPointer  <= ptrWord;
		end
		else
		begin
			if (wrEnq && reqReady && curSel == SEL_DATA_AUTO)
				writeAddressPointer <= writeAddressPointer + ADDR_STEP;
			else if (cpuPtrWrEn && !cpuPtrSelRead)
				writeAddressPointer <= cpuPtrData;
			if (strobeRise && curRnw && curLast && curSel == SEL_DATA_AUTO)
				readAddressPointer <= readAddressPointer + ADDR_STEP;
			else if (cpuPtrWrEn && cpuPtrSelRead)
				readAddressPointer <= cpuPtrData;
		end
	end

	// ==========================================================
	// control bits and interrupts
	logic ctlWrite;

	assign ctlWrite = hostWrite && curSel == SEL_CONTROL;

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			halfwordOrder <= 1'b0;
			dspIrq        <= 1'b0;
			hostIrqN      <= 1'b1;
		end
		else
		begin
			if (ctlWrite)
				halfwordOrder <= wrData_r[BIT_ORDER];
			dspIrq <= ctlWrite && wrData_r[BIT_DSP_IRQ];
			// DSP sets, host writes one to clear; set wins
			if (cpuHostIrqSet)
				hostIrqN <= 1'b0;
			else if (ctlWrite && wrData_r[BIT_HOST_IRQ])
				hostIrqN <= 1'b1;
		end
	end

	// ==========================================================
	// pin outputs
	logic driveNow;

	assign driveNow = rawStrobe && readNotWrite && (rdState_r != RD_WAIT);

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			hostDataOut    <= '0;
			hostDataOeLow  <= 1'b0;
			hostDataOeHigh <= 1'b0;
			portNotReady   <= 1'b0;
			// follow the strap so the width flag never steps at release
			widePortMode   <= widePortStrap;
		end
		else
		begin
			widePortMode <= wide_r;
			hostDataOut <= wide_r ? rdWord_r
				: {{HALF_W{1'b0}}, pickHalf(rdWord_r, identLat_r, halfwordOrder)};
			hostDataOeLow  <= driveNow;
			hostDataOeHigh <= driveNow && wide_r;
			portNotReady <= !portSelectN && busy;
		end
	end

endmodule : hpif_port

/* dv/hpif_port_properties.sv */
// concurrent checks on the host port block's pins
`timescale 1ns/1ps
// ==========================================================
// checker
module hpif_port_properties
	import hpif_pkg::*;
(
	// clock and reset
	input logic              mclk,
	input logic              srst,
	// host pins
	input logic [DATA_W-1:0] hostDataOut,
	input logic              hostDataOeLow,
	input logic              hostDataOeHigh,
	input logic              readNotWrite,
	input logic              portSelectN,
	input logic              dataStrobeAN,
	input logic              dataStrobeBN,
	input logic              portNotReady,
	input logic              hostIrqN,
	// memory and cpu side
	input logic              memReqValid,
	input logic              memReqReady,
	input hpif_req_s         memReq,
	input logic              cpuHostIrqSet,
	input logic              widePortMode
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	sequence sIrqSet;
		cpuHostIrqSet ##1 !hostIrqN;
	endsequence
	sequence sStall;
		memReqValid && !memReqReady;
	endsequence

	AST_DESEL_READY: assert property (portSelectN && $past(portSelectN) |-> !portNotReady)
		else $error("busy shown while deselected");
	AST_OE_LOW_CAUSE: assert property (hostDataOeLow |->
		$past(!portSelectN && (dataStrobeAN ^ dataStrobeBN) && readNotWrite))
		else $error("low data pins driven outside a read strobe");
	AST_OE_HIGH_WIDE: assert property (hostDataOeHigh |-> widePortMode)
		else $error("upper data pins driven in narrow mode");
	AST_NARROW_UPPER: assert property (hostDataOeLow && !widePortMode |->
		hostDataOut[31:16] == 16'h0000)
		else $error("narrow read carries upper bits");
	AST_RESET_STATE: assert property ($fell(srst) |-> hostIrqN && !hostDataOeLow)
		else $error("host interrupt or bus wrong after reset");
	AST_WIDTH_FIXED: assert property (!$past(srst) |-> $stable(widePortMode))
		else $error("port width changed outside reset");
	AST_WORD_LSB: assert property (memReqValid |-> memReq.lsb == LSB_WORD)
		else $error("word request with nonzero low address bits");
	AST_IRQ_SET: assert property (cpuHostIrqSet |-> sIrqSet)
		else $error("host interrupt not raised by cpu");
	AST_IRQ_CAUSE: assert property ($fell(hostIrqN) |-> $past(cpuHostIrqSet))
		else $error("host interrupt raised without cpu request");
	AST_REQ_HOLD: assert property (sStall |=> memReqValid && $stable(memReq))
		else $error("pending request changed before taken");
endmodule : hpif_port_properties

/* dv/hpif_mem_model.sv */
// memory-side partner answering the host port's requests
`timescale 1ns/1ps
// ==========================================================
// memory model
module hpif_mem_model
	import hpif_pkg::*;
(
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              srst,
	// bench control
	input  wire logic              stall,
	// request side
	input  wire logic              memReqValid,
	output logic                   memReqReady,
	input  wire hpif_req_s         memReq,
	output logic                   memRdValid,
	output logic      [DATA_W-1:0] memRdData
);
	logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
	logic [ADDR_W-1:0] pend [$];
	logic [ADDR_W-1:0] a;
	initial
	begin
		memReqReady = 1'b0;
		memRdValid = 1'b0;
		memRdData = 32'h0000_0000;
	end
	always @(posedge mclk)
	begin
		memRdValid <= 1'b0;
		// idle data toggles so stale values never pass
		memRdData <= ~memRdData;
		memReqReady <= !stall && !srst && 1'($urandom_range(0, 1));
		if (srst)
			pend.delete();
		else if (pend.size() > 0 && $urandom_range(0, 2) == 0)
		begin
			a = pend.pop_front();
			memRdValid <= 1'b1;
			memRdData <= mem.exists(a) ? mem[a] : ~a;
		end
		if (memReqValid && memReqReady && memReq.write)
			mem[memReq.addr] = memReq.wdata;
		else if (memReqValid && memReqReady)
			pend.push_back(memReq.addr);
	end
endmodule : hpif_mem_model

/* dv/tb_hpif_port.sv */
// self-checking bench for the host port block
`timescale 1ns/1ps
// ==========================================================
// bench top
module tb_hpif_port;
	import hpif_pkg::*;
	logic mclk = 1'b0, srst = 1'b1, widePortStrap = 1'b0, stall = 1'b0;
	logic littleEndianStrap = 1'b0, addrStrobeN = 1'b1, useAs = 1'b0;
	logic [1:0] accessSelect = 2'h0;
	logic halfwordIdent = 1'b0, readNotWrite = 1'b1, portSelectN = 1'b1;
	logic dataStrobeAN = 1'b1, dataStrobeBN = 1'b1, cpuPtrWrEn = 1'b0;
	logic cpuPtrSelRead = 1'b0, cpuHostIrqSet = 1'b0, wide = 1'b0, ord = 1'b0;
	logic [31:0] cpuPtrData = 32'h0000_0000, hostDrive = 32'h0000_0000, q;
	logic [31:0] hostDataOut, memRdData, writeAddressPointer, readAddressPointer;
	logic hostDataOeLow, hostDataOeHigh, portNotReady, hostIrqN, memReqValid;
	logic memReqReady, memRdValid, halfwordOrder, widePortMode, dspIrq;
	hpif_req_s memReq;
	wire logic [31:0] hostDataIn = {hostDataOeHigh ? hostDataOut[31:16] : hostDrive[31:16],
		hostDataOeLow ? hostDataOut[15:0] : hostDrive[15:0]};
	int fails = 0, compares = 0;
	int dspPulses = 0;

	hpif_port #(.DEPTH(FIFO_DEPTH)) hpif_port_inst (.mclk, .srst, .widePortStrap,
		.littleEndianStrap, .hostDataIn, .hostDataOut, .hostDataOeLow, .hostDataOeHigh,
		.accessSelect, .halfwordIdent, .readNotWrite, .portSelectN, .dataStrobeAN,
		.dataStrobeBN, .addrStrobeN, .portNotReady, .hostIrqN, .memReqValid, .memReqReady,
		.memReq, .memRdValid, .memRdData, .cpuPtrWrEn, .cpuPtrSelRead, .cpuPtrData,
		.cpuHostIrqSet, .writeAddressPointer, .readAddressPointer, .halfwordOrder,
		.widePortMode, .dspIrq);
	hpif_mem_model hpif_mem_model_inst (.mclk, .srst, .stall, .memReqValid, .memReqReady,
		.memReq, .memRdValid, .memRdData);

	initial forever #25 mclk = ~mclk;

	always @(posedge mclk)
		if (dspIrq === 1'b1)
			dspPulses++;

	task automatic tick();
		@(posedge mclk);
		#5;
	endtask : tick
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic conclude();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	task automatic doReset(input logic w);
		srst = 1'b1;
		widePortStrap = w;
		wide = w;
		ord = 1'b0;
		repeat (12) tick();
		srst = 1'b0;
		repeat (4) tick();
	endtask : doReset
	// one strobe cycle; reads on the second strobe pin, writes on the first
	task automatic xfer(input logic [1:0] sel, input logic rnw, input logic hid,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		accessSelect = sel;
		readNotWrite = rnw;
		halfwordIdent = hid;
		hostDrive = d;
		// controls taken at address strobe, then select and ident scrambled
		if (useAs)
		begin
			addrStrobeN = 1'b0;
			repeat (4) tick();
			addrStrobeN = 1'b1;
			accessSelect = ~sel;
			halfwordIdent = ~hid;
		end
		portSelectN = 1'b0;
		tick();
		dataStrobeAN = rnw;
		dataStrobeBN = !rnw;
		// strobes pass a synchroniser, so busy shows late
		repeat (6) tick();
		for (n = 0; n < 200 && portNotReady !== 1'b0; n++)
			tick();
		if (n == 200)
		begin
			check("ready wait", 32'h0, 32'h1);
			conclude();
		end
		repeat (2) tick();
		r = hostDataOut;
		dataStrobeAN = 1'b1;
		dataStrobeBN = 1'b1;
		portSelectN = 1'b1;
		hostDrive = ~d;
		repeat (6) tick();
	endtask : xfer
	task automatic word(input logic [1:0] sel, input logic rnw, input logic [31:0] d,
		output logic [31:0] r);
		logic [31:0] a, b;
		logic [15:0] junk;
		junk = 16'($urandom());
		if (wide)
			xfer(sel, rnw, 1'($urandom_range(0, 1)), d, r);
		else
		begin
			xfer(sel, rnw, 1'b0, {junk, ord ? d[15:0] : d[31:16]}, a);
			xfer(sel, rnw, 1'b1, {~junk, ord ? d[31:16] : d[15:0]}, b);
			r = ord ? {b[15:0], a[15:0]} : {a[15:0], b[15:0]};
		end
	endtask : word
	task automatic trip(input logic [31:0] a, input logic [31:0] d, input logic [1:0] sel);
		logic [31:0] step, r;
		step = (sel == SEL_DATA_AUTO) ? ADDR_STEP : 32'h0000_0000;
		word(SEL_POINTER, 1'b0, a, r);
		check("write pointer", a, writeAddressPointer);
		check("read pointer", a, readAddressPointer);
		word(SEL_POINTER, 1'b1, 32'h0000_0000, r);
		check("pointer read", a, r);
		word(sel, 1'b0, d, r);
		check("write pointer step", a + step, writeAddressPointer);
		repeat (20) tick();
		check("memory word", d, hpif_mem_model_inst.mem[a]);
		word(sel, 1'b1, 32'h0000_0000, r);
		check("read word", d, r);
		check("read pointer step", a + step, readAddressPointer);
	endtask : trip

	initial
	begin
		int i;
		void'($urandom(32'h1e77));
		doReset(1'b0);
		check("irq after reset", 32'h1, hostIrqN);
		check("narrow mode", 32'h0, widePortMode);
		for (i = 0; i < 4; i++)
		begin
			ord = i[1];
			useAs = i[0];
			word(SEL_CONTROL, 1'b0, ord ? 32'h0005_0005 : 32'h0004_0004, q);
			check("order bit", 32'(ord), halfwordOrder);
			trip({22'h0, 8'($urandom()), 2'h0}, $urandom(), i[0] ? SEL_DATA_FIX : SEL_DATA_AUTO);
		end
		cpuPtrData = 32'h0000_0100;
		cpuPtrSelRead = 1'b1;
		cpuPtrWrEn = 1'b1;
		tick();
		cpuPtrWrEn = 1'b0;
		tick();
		check("cpu read pointer", 32'h0000_0100, readAddressPointer);
		cpuHostIrqSet = 1'b1;
		tick();
		cpuHostIrqSet = 1'b0;
		tick();
		check("irq raised", 32'h0, hostIrqN);
		word(SEL_CONTROL, 1'b1, 32'h0000_0000, q);
		check("control read", (32'h1 << BIT_ORDER) | (32'h1 << BIT_HOST_IRQ), q);
		word(SEL_CONTROL, 1'b0, 32'h0006_0006, q);
		check("irq cleared", 32'h1, hostIrqN);
		check("dsp irq pulses", 32'h2, 32'(dspPulses));
		doReset(1'b1);
		check("wide mode", 32'h1, widePortMode);
		trip(32'h0000_0040, $urandom(), SEL_DATA_AUTO);
		// far side stalls while the buffer fills
		stall = 1'b1;
		for (i = 0; i < 4; i++)
			word(SEL_DATA_AUTO, 1'b0, 32'(i), q);
		portSelectN = 1'b0;
		repeat (2) tick();
		check("full busy", 32'h1, portNotReady);
		portSelectN = 1'b1;
		repeat (2) tick();
		check("deselected ready", 32'h0, portNotReady);
		stall = 1'b0;
		repeat (40) tick();
		for (i = 0; i < 4; i++)
			check("drained", 32'(i), hpif_mem_model_inst.mem[32'h44 + 32'(4 * i)]);
		conclude();
	end
endmodule : tb_hpif_port

bind hpif_port hpif_port_properties hpif_port_properties_inst (.mclk, .srst, .hostDataOut,
	.hostDataOeLow, .hostDataOeHigh, .readNotWrite, .portSelectN, .dataStrobeAN,
	.dataStrobeBN, .portNotReady, .hostIrqN, .memReqValid, .memReqReady, .memReq,
	.cpuHostIrqSet, .widePortMode);
